// ===== verilog/pbsram_cfg.svh
`ifndef PBSRAM_CFG_SVH
`define PBSRAM_CFG_SVH
// Latency, burst length, FIFO depth and burst order constants
`define PBS_LAT_STAGES 2
`define PBS_BURST_LEN 3'h4
`define PBS_FIFO_DEPTH 4
`define PBS_ORDER_LINEAR 1'h0
`define PBS_ORDER_INTERLEAVE 1'h1
`endif

// ===== verilog/pbsram_pkg.sv
`default_nettype none
package pbsram_pkg;
    // Operation of one pipeline slot
    typedef enum logic [1:0] {
        PBS_OP_NONE,
        PBS_OP_READ,
        PBS_OP_WRITE
    } pbs_op_type;

    // Command pins as one group
    typedef struct packed {
        logic        clock_hold_n;
        logic        advance_or_load_n;
        logic        rw_n;
        logic        chip_select_a_n;
        logic        chip_select_b_n;
        logic        chip_select_b;
        logic [3:0]  byte_write_strobe_n;
        logic [16:0] addr;
    } pbs_cmd_type;

    // One slot of the two-edge data pipeline
    typedef struct packed {
        pbs_op_type  op;
        logic [16:0] addr;
        logic [3:0]  lanes;
    } pbs_slot_type;
endpackage
`default_nettype wire

// ===== verilog/pbsram_fifo.sv
`default_nettype none
// Small valid/ready FIFO holding write words before the array
module pbsram_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    // Storage array and pointers
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    // Honest full and empty
    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + AW'(1);
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + AW'(1);
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Data storage, no reset needed
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/pbsram_dev.sv
`include "pbsram_cfg.svh"
`default_nettype none
// What this block does
// - Selected load read, data out two edges later
// - Selected load write, data captured two edges later
// - Advance increments burst address, next transfer
// - Advance ignores selects; direction from load
// - Load with false select starts deselect
// - Deselect finishes pipeline, bus floats two later
// - Advance after deselect or idle does nothing
// - Selected only when all three selects true
// - Clock hold high freezes pipeline and burst state
// - Held edges do not count toward latency
// - Data outputs float from first edge
// - Low strobe writes its byte and parity
// - Any strobe combination writes together
// - Narrow build has only two lanes
// - Order pin high gives interleaved sequence
// - Order pin low gives linear sequence
// - Burst counter wraps after four transfers
// - Any load cycle ends the burst
// - Undriven order pin defaults to interleaved
module pbsram_dev
    import pbsram_pkg::*;
#(
    parameter int ADDR_W = 17,
    parameter int LANES  = 4,
    parameter int WORDS  = 64
) (
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire pbsram_pkg::pbs_cmd_type cmd,
    input  wire logic              burst_order_select_n,
    input  wire logic              burst_order_driven,
    input  wire logic              out_enable_n,
    input  wire logic [LANES*9-1:0] data_in,
    output logic [LANES*9-1:0]     data_out,
    output logic                   data_oe_n,
    output logic                   write_stall
);
    import pbsram_pkg::*;

    localparam int DW = LANES * 9;
    localparam int MW = $clog2(WORDS);

    // Pipeline, burst, output and order state of the block; FIFO and lane arrays kept apart
    typedef struct packed {
        pbs_slot_type [1:0] pipe;
        pbs_op_type         burst_op;
        logic [ADDR_W-1:0]  base;
        logic [1:0]         count;
        logic [DW-1:0]      dout;
        logic               drive;
        logic [2:0]         order_sync;
        logic               order_level; // Order pin once two stages agree
    } pbs_state_type;

    pbs_state_type st_ff;
    pbs_state_type nxt_st;

    // Read port of the lane arrays, with bypass of the FIFO head
    logic [MW-1:0]      rd_addr;
    wire logic [DW-1:0] rd_word;

    // Write path through the FIFO
    logic                        wf_in_ready;
    logic                        wf_out_valid;
    logic [MW+LANES+DW-1:0]      wf_out_data;
    logic [MW+LANES+DW-1:0]      wf_in_data;
    logic                        wf_in_valid;
    logic                        enabled;
    logic                        selected;
    logic                        order_il;

    // Low address bits of a burst step
    function automatic logic [1:0] burst_low(input logic [1:0] start,
                                             input logic [1:0] n,
                                             input logic       il);
        burst_low = il ? (start ^ n) : 2'(start + n);
    endfunction

    // Byte strobes to active lane mask
    function automatic logic [LANES-1:0] lane_mask(input logic [3:0] bw_n);
        lane_mask = ~bw_n[LANES-1:0];
    endfunction

    // Held edges and FIFO back-pressure freeze the pipeline and burst state
    assign enabled  = !cmd.clock_hold_n && wf_in_ready;
    assign selected = !cmd.chip_select_a_n && !cmd.chip_select_b_n
                      && cmd.chip_select_b;
    // Order pin after its synchroniser; undriven means high
    assign order_il = !burst_order_driven ? 1'b1
                    : st_ff.order_level;
    // Array word read for the slot that matures at this edge
    assign rd_addr  = st_ff.pipe[1].addr[MW-1:0];

    // Write captured data enters FIFO when its slot matures
    assign wf_in_valid = enabled && (st_ff.pipe[1].op == PBS_OP_WRITE);
    assign wf_in_data  = {st_ff.pipe[1].addr[MW-1:0],
                          st_ff.pipe[1].lanes[LANES-1:0], data_in};

    // Next-state logic
    always_comb begin
        nxt_st = st_ff;
        nxt_st.order_sync = {st_ff.order_sync[1:0], burst_order_select_n};
        // A change counts only once the second and third stage agree
        if (st_ff.order_sync[2] == st_ff.order_sync[1]) begin
            nxt_st.order_level = st_ff.order_sync[2];
        end
        if (enabled) begin
            // Shift the two-stage pipeline
            nxt_st.pipe[1] = st_ff.pipe[0];
            nxt_st.pipe[0] = '{op: PBS_OP_NONE, addr: '0, lanes: '0};
            if (!cmd.advance_or_load_n) begin
                // Load cycle ends any burst
                nxt_st.count = 2'h0;
                if (selected) begin
                    nxt_st.base     = cmd.addr[ADDR_W-1:0];
                    // Direction fixed here for the whole burst
                    nxt_st.burst_op = cmd.rw_n ? PBS_OP_READ
                                    : PBS_OP_WRITE;
                    nxt_st.pipe[0].op    = nxt_st.burst_op;
                    nxt_st.pipe[0].addr  = cmd.addr[ADDR_W-1:0];
                    // Strobes ride with the command cycle
                    nxt_st.pipe[0].lanes =
                        4'(lane_mask(cmd.byte_write_strobe_n));
                end else begin
                    nxt_st.burst_op = PBS_OP_NONE;
                end
            end else if (st_ff.burst_op != PBS_OP_NONE) begin
                // Advance: selects and direction pins ignored
                nxt_st.count = st_ff.count + 2'h1;
                nxt_st.pipe[0].op    = st_ff.burst_op;
                nxt_st.pipe[0].addr  = {st_ff.base[ADDR_W-1:2],
                    burst_low(st_ff.base[1:0], nxt_st.count, order_il)};
                nxt_st.pipe[0].lanes =
                    4'(lane_mask(cmd.byte_write_strobe_n));
            end
            // Otherwise idle_cycle after deselect: nothing starts
            // Output stage: drive only for a maturing read
            nxt_st.drive = (st_ff.pipe[1].op == PBS_OP_READ);
            if (st_ff.pipe[1].op == PBS_OP_READ) begin
                nxt_st.dout = rd_word;
            end
        end
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // FIFO drains into the array one word per edge
    pbsram_fifo #(
        .WIDTH (MW + LANES + DW),
        .DEPTH (`PBS_FIFO_DEPTH)
    ) u_wfifo (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .in_valid  (wf_in_valid),
        .in_ready  (wf_in_ready),
        .in_data   (wf_in_data),
        .out_valid (wf_out_valid),
        .out_ready (1'b1),
        .out_data  (wf_out_data)
    );

    // Lane-wise storage; each lane owns its array so one process writes it
    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            logic [8:0] lane_mem_ff [WORDS]; // Byte and parity per word
            logic       hit;                 // FIFO head is newer data
            // A write that left the pipeline one edge ago is still in the
            // FIFO; a read of that word must see it, not the stale array
            assign hit = wf_out_valid && wf_out_data[DW+g]
                         && (wf_out_data[MW+LANES+DW-1:LANES+DW] == rd_addr);
            // Read with bypass
            assign rd_word[g*9+:9] = hit ? wf_out_data[g*9+:9]
                                         : lane_mem_ff[rd_addr];
            // Lane write from the FIFO head
            always_ff @(posedge mclk) begin
                if (wf_out_valid && wf_out_data[DW+g]) begin
                    lane_mem_ff[wf_out_data[MW+LANES+DW-1:LANES+DW]]
                        <= wf_out_data[g*9+:9];
                end
            end
        end
    endgenerate

    // Registered outputs; a hazard of a read right behind a write is
    // avoided by the bypass of the FIFO head in each lane
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            data_out    <= '0;
            data_oe_n   <= 1'b1;
            write_stall <= 1'b0;
        end else begin
            data_out    <= nxt_st.dout;
            data_oe_n   <= !(nxt_st.drive && !out_enable_n);
            write_stall <= !wf_in_ready;
        end
    end

    // Two-edge read latency with enabled edges
    sequence s_read_load;
        enabled && !cmd.advance_or_load_n && selected && cmd.rw_n;
    endsequence

    // Read slot reaching the output stage with the enable low
    sequence s_read_mature;
        enabled && st_ff.pipe[1].op == PBS_OP_READ && !out_enable_n;
    endsequence

    chk_read_latency: assert property (@(posedge mclk) disable iff (!arst_n)
        s_read_load |=> st_ff.pipe[0].op == PBS_OP_READ)
        else $error("read not queued");
    chk_read_drive: assert property (@(posedge mclk) disable iff (!arst_n)
        s_read_mature |=> !data_oe_n)
        else $error("read data not driven");
    chk_bus_float: assert property (@(posedge mclk) disable iff (!arst_n)
        (enabled && st_ff.pipe[1].op != PBS_OP_READ) |=> data_oe_n)
        else $error("bus driven without read");
    chk_order_linear: assert property (@(posedge mclk) disable iff (!arst_n)
        (enabled && cmd.advance_or_load_n && st_ff.burst_op != PBS_OP_NONE
         && !order_il)
        |=> st_ff.pipe[0].addr[1:0] == 2'(st_ff.base[1:0] + st_ff.count))
        else $error("linear order broken");
    chk_order_inter: assert property (@(posedge mclk) disable iff (!arst_n)
        (enabled && cmd.advance_or_load_n && st_ff.burst_op != PBS_OP_NONE
         && order_il)
        |=> st_ff.pipe[0].addr[1:0] == (st_ff.base[1:0] ^ st_ff.count))
        else $error("interleaved order broken");
    chk_write_slot: assert property (@(posedge mclk) disable iff (!arst_n)
        (enabled && !cmd.advance_or_load_n && selected && !cmd.rw_n)
        |=> st_ff.pipe[0].op == PBS_OP_WRITE)
        else $error("write not queued");
    chk_burst_count: assert property (@(posedge mclk) disable iff (!arst_n)
        (enabled && cmd.advance_or_load_n && st_ff.burst_op != PBS_OP_NONE)
        |=> st_ff.count == $past(st_ff.count) + 2'h1)
        else $error("burst count stuck");
    chk_burst_dir: assert property (@(posedge mclk) disable iff (!arst_n)
        (enabled && cmd.advance_or_load_n)
        |=> st_ff.burst_op == $past(st_ff.burst_op))
        else $error("burst direction changed");
    chk_deselect: assert property (@(posedge mclk) disable iff (!arst_n)
        (enabled && !cmd.advance_or_load_n && !selected)
        |=> st_ff.pipe[0].op == PBS_OP_NONE)
        else $error("deselect started op");
    chk_hold_freeze: assert property (@(posedge mclk) disable iff (!arst_n)
        cmd.clock_hold_n |=> $stable(st_ff.pipe) && $stable(data_oe_n))
        else $error("held edge changed state");
    chk_oe_float: assert property (@(posedge mclk) disable iff (!arst_n)
        out_enable_n |=> data_oe_n)
        else $error("bus driven with enable high");
    chk_idle_none: assert property (@(posedge mclk) disable iff (!arst_n)
        (enabled && cmd.advance_or_load_n && st_ff.burst_op == PBS_OP_NONE)
        |=> st_ff.pipe[0].op == PBS_OP_NONE)
        else $error("idle cycle started op");
endmodule
`default_nettype wire

// ===== tb/pbs_ctrl_model.sv
`default_nettype none
// Controller side: puts write data on the bus two enabled edges late
module pbs_ctrl_model (
    input  wire logic        mclk,
    input  wire logic        clock_hold_n,
    input  wire logic        wr_valid,
    input  wire logic [35:0] wr_data,
    output logic [35:0]      data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  vld_ff = 2'h0;  // Write words in flight
    logic [35:0] dat_ff = 36'h0; // Word taken at the last edge
    initial data_in = 36'h0;
    // Held edges keep only a pending write word; a released bus keeps toggling
    always @(posedge mclk) begin
        if (!clock_hold_n) begin
            vld_ff <= {vld_ff[0], wr_valid};
            dat_ff <= wr_data;
            data_in <= vld_ff[0] ? dat_ff : ~data_in;
        end else if (!vld_ff[1]) begin
            data_in <= ~data_in;
        end
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
// Random command stream checked against a mirror of the array
module testbench;
    import pbsram_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic         mclk = 1'h0;
    logic         arst_n = 1'h0;
    pbs_cmd_type  cmd = '0;
    logic         ord_n = 1'h1;     // Burst order pin
    logic         ord_drv = 1'h1;   // Order pin is driven
    logic         oe_n = 1'h0;      // Output enable, low drives
    logic         wr_v = 1'h0;      // Write transfer this cycle
    logic [35:0]  wr_d = 36'h0;     // Its data word
    logic [35:0]  data_in;
    logic [35:0]  data_out;
    logic         data_oe_n;
    logic         write_stall;
    logic [35:0]  mem [64];         // Expected array contents
    pbs_slot_type pipe [2] = '{default: '0}; // Transfers in flight
    logic [35:0]  pipe_d [2];       // Their write words
    pbs_op_type   b_op = PBS_OP_NONE; // Direction of current burst
    logic [16:0]  b_base = 17'h0;   // Burst start address
    logic [1:0]   b_cnt = 2'h0;     // Burst position
    int           n_fail = 0;
    int           checks_done = 0;
    // Free running clock
    always #2.5 mclk = ~mclk;
    pbsram_dev #(.ADDR_W(17), .LANES(4), .WORDS(64)) DUT (
        .mclk(mclk), .arst_n(arst_n), .cmd(cmd),
        .burst_order_select_n(ord_n), .burst_order_driven(ord_drv),
        .out_enable_n(oe_n), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .write_stall(write_stall));
    pbs_ctrl_model ctrl (.mclk(mclk), .clock_hold_n(cmd.clock_hold_n),
        .wr_valid(wr_v), .wr_data(wr_d), .data_in(data_in));
    // Compare one flag
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Compare one data word
    task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Address of a burst step in the chosen order
    function automatic logic [16:0] b_addr(input logic [1:0] n);
        b_addr = b_base;
        b_addr[1:0] = (ord_drv ? ord_n : 1'h1) ? b_base[1:0] ^ n
                                               : b_base[1:0] + n;
    endfunction
    // Word after a write of the enabled lanes
    function automatic logic [35:0] merge(input logic [35:0] old,
        input logic [35:0] nw, input logic [3:0] ln);
        merge = old;
        for (int i = 0; i < 4; i++)
            if (ln[i]) merge[9*i +: 9] = nw[9*i +: 9];
    endfunction
    // One clock: predict, drive, then check after the edge
    task automatic cyc(input pbs_cmd_type c);
        pbs_slot_type s;
        logic         o_prev;
        logic [35:0]  d_prev;
        s = '0;
        if (!c.clock_hold_n) begin
            if (!c.advance_or_load_n) begin
                b_op = PBS_OP_NONE;
                if (!c.chip_select_a_n && !c.chip_select_b_n
                    && c.chip_select_b) begin
                    b_op = c.rw_n ? PBS_OP_READ : PBS_OP_WRITE;
                    b_base = c.addr;
                    b_cnt = 2'h0;
                end
            end else if (b_op != PBS_OP_NONE) begin
                b_cnt++;
            end
            s.op = b_op;
            s.addr = b_addr(b_cnt);
            s.lanes = ~c.byte_write_strobe_n;
        end
        cmd = c;
        wr_v = !c.clock_hold_n && s.op == PBS_OP_WRITE;
        wr_d = {4'($urandom), 32'($urandom)};
        o_prev = data_oe_n;
        d_prev = data_out;
        @(posedge mclk);
        #1;
        chk_bit(write_stall, 1'h0);
        if (c.clock_hold_n) begin
            chk_bit(data_oe_n, o_prev);
            if (!o_prev) chk_word(data_out, d_prev);
        end else begin
            if (oe_n) chk_bit(data_oe_n, 1'h1);
            else chk_bit(data_oe_n, pipe[1].op != PBS_OP_READ);
            if (!oe_n && pipe[1].op == PBS_OP_READ)
                chk_word(data_out, mem[pipe[1].addr[5:0]]);
            if (pipe[1].op == PBS_OP_WRITE)
                mem[pipe[1].addr[5:0]] = merge(mem[pipe[1].addr[5:0]],
                    pipe_d[1], pipe[1].lanes);
            pipe[1] = pipe[0];
            pipe_d[1] = pipe_d[0];
            pipe[0] = s;
            pipe_d[0] = wr_d;
        end
    endtask
    // Random load, advance, deselect or held cycle
    task automatic rnd_cyc();
        pbs_cmd_type c;
        int          k;
        c = 27'($urandom);
        k = $urandom_range(99);
        c.addr[16:6] = 11'h0;
        c.clock_hold_n = (k < 12);
        c.advance_or_load_n = (k < 55);
        if (k >= 55) begin
            c.chip_select_a_n = 1'h0;
            c.chip_select_b_n = 1'h0;
            c.chip_select_b = 1'h1;
            if (k < 70) begin
                case ($urandom_range(2))
                    0: c.chip_select_a_n = 1'h1;
                    1: c.chip_select_b_n = 1'h1;
                    default: c.chip_select_b = 1'h0;
                endcase
            end
        end
        if (!c.clock_hold_n) oe_n = ($urandom_range(9) == 0);
        cyc(c);
    endtask
    // Print the counts and the verdict, then stop
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Cut a hang short
    initial begin
        #100000;
        n_fail++;
        complete_run();
    end
    // Main sequence
    initial begin
        pbs_cmd_type c;
        void'($urandom(49094));
        repeat (3) @(posedge mclk);
        #1;
        arst_n = 1'h1;
        chk_bit(data_oe_n, 1'h1);
        // Fill every word back to back
        for (int i = 0; i < 64; i++) begin
            c = '0;
            c.chip_select_b = 1'h1;
            c.addr = 17'(i);
            cyc(c);
        end
        // Linear, interleaved, then an undriven order pin
        for (int p = 0; p < 3; p++) begin
            ord_drv = (p != 2);
            ord_n = (p == 1);
            repeat (6) cyc('0);
            // Write then read burst, each wrapping once, direction pins flipped
            for (int w = 0; w < 2; w++) begin
                c = 27'($urandom);
                c.addr = 17'h0B;
                c.clock_hold_n = 1'h0;
                c.advance_or_load_n = 1'h0;
                c.rw_n = w[0];
                c.chip_select_a_n = 1'h0;
                c.chip_select_b_n = 1'h0;
                c.chip_select_b = 1'h1;
                cyc(c);
                c.advance_or_load_n = 1'h1;
                c.rw_n = !w[0];
                c.chip_select_b = 1'h0;
                repeat (5) cyc(c);
            end
            repeat (250) rnd_cyc();
        end
        repeat (3) cyc('0);
        complete_run();
    end
endmodule
`default_nettype wire
